// ===== hdl/scd_ctrl.sv
// system control low bits, event pin routing and media card-detect debounce
//
// Contract
// - data parity errors go to the system error request only while parity_report_enable is set.
// - bit 3 of the system control register is reserved and always reads zero.
// - legacy_socket_voltage is read-only, 0 means 3.3 V (default) and 1 means 5 V.
// - while clock_keep_on is set, clock-run keeps the system clock and card_bus_clock running.
// - while clock_keep_on is clear (default) both clocks may be stopped.
// - the global bits exist once and software changes them only through function 0.
// - with event_pin_select at 1 the power-management event drives the shared pin.
// - event_pin_select 0 and ring_indicate_enable 1 put the ring_indicate_output on the pin.
// - with both event_pin_select and ring_indicate_enable at 0 the shared pin is not driven.
// - the system control bits are cleared only by global_reset, never by other resets.
// - media_card_detect is debounced for the debounce register value times 2 ms; the filter here accepts only after value + 1 ticks of 2 ms.
// - the debounce register resets to 19h, i.e. 50 ms.
// - the debounce register is initialised only by global_reset.
// - global_reset clears every global-reset-only bit regardless of any bus or function reset.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "scd_regs.svh"

module scd_ctrl
    import scd_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `SCD_TICK_US * `SCD_CLK_MHZ
) (
    // clock and resets
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        bus_rst_b,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [2:0]  reg_func,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // parity error reporting
    input  wire logic        cb_parity_err,
    output logic             serr_req,
    // socket power indication
    input  wire logic        legacy_socket_voltage,
    // clock-run
    input  wire logic        clk_stop_req,
    output logic             clkrun_hold,
    output logic             card_bus_clock_stop_ok,
    // shared event / ring-indicate pin
    input  wire logic        pme_event,
    input  wire logic        ring_indicate_output,
    input  wire logic        ring_indicate_enable,
    output logic             event_pin_out,
    output logic             event_pin_oe,
    // media card detect
    input  wire logic        media_card_detect,
    output logic             media_card_present,
    // interrupt
    output logic             irq
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic scd_hit(input logic [7:0] a, input logic [7:0] off);
        scd_hit = (a == off);
    endfunction : scd_hit

    localparam logic [16:0] PRESC_LAST = `SCD_PRESC_W'(TICK_CYCLES - 1);

    scd_state_t s_q;
    scd_state_t s_d;

    logic wr_sysctl;
    logic wr_deb;
    logic wr_sts;
    logic wr_msk;
    logic [`SCD_IRQ_N-1:0] irq_set;

    assign wr_sysctl = reg_wr && scd_hit(reg_addr, `SCD_OFF_SYSCTL)
                       && (reg_func == `SCD_FUNC_GLOBAL);
    assign wr_deb    = reg_wr && scd_hit(reg_addr, `SCD_OFF_DEBOUNCE);
    assign wr_sts    = reg_wr && scd_hit(reg_addr, `SCD_OFF_IRQ_STS);
    assign wr_msk    = reg_wr && scd_hit(reg_addr, `SCD_OFF_IRQ_MSK);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // global bits: one copy, written only through function 0
        if (wr_sysctl) begin
            s_d.parity_en = reg_wdata[`SCD_SC_PAR_EN];
            s_d.keep      = reg_wdata[`SCD_SC_KEEP];
            s_d.pin_sel   = reg_wdata[`SCD_SC_PIN_SEL];
        end
        if (wr_deb) begin
            s_d.deb = reg_wdata[7:0];
        end
        if (wr_msk) begin
            s_d.irq_msk = reg_wdata[`SCD_IRQ_N-1:0];
        end
        s_d.volt = legacy_socket_voltage;

        // parity error towards the system error line
        s_d.serr = cb_parity_err && s_q.parity_en;

        // clock-run: hold the system clock only when asked to stop and keep is on; card clock stop_ok follows keep alone
        s_d.clkrun_hold  = s_q.keep && clk_stop_req;
        s_d.card_stop_ok = !s_q.keep;

        // shared pin routing
        if (s_q.pin_sel) begin
            s_d.pin_out = pme_event;
            s_d.pin_oe  = 1'h1;
        end else if (ring_indicate_enable) begin
            s_d.pin_out = ring_indicate_output;
            s_d.pin_oe  = 1'h1;
        end else begin
            s_d.pin_out = 1'h0;
            s_d.pin_oe  = 1'h0;
        end

        // free-running 2 ms base, never restarted by the filter
        s_d.tick = (s_q.presc == PRESC_LAST);
        if (s_q.presc == PRESC_LAST) begin
            s_d.presc = '0;
        end else begin
            s_d.presc = s_q.presc + 17'h00001;
        end

        // debounce filter
        s_d.raw = media_card_detect;
        irq_set = '0;
        case (s_q.st)
            SCD_ST_STABLE: begin
                if (s_q.raw != s_q.present) begin
                    s_d.st       = SCD_ST_SETTLE;
                    s_d.tick_cnt = '0;
                    s_d.limit    = s_q.deb;
                end
            end
            SCD_ST_SETTLE: begin
                if (s_q.raw == s_q.present) begin
                    s_d.st = SCD_ST_STABLE;
                end else if (s_q.tick_cnt > {1'h0, s_q.limit}) begin
                    s_d.present = s_q.raw;
                    s_d.st      = SCD_ST_STABLE;
                    irq_set[`SCD_IRQ_CD_CHG] = 1'h1;
                end else if (s_q.tick) begin
                    s_d.tick_cnt = s_q.tick_cnt + 9'h001;
                end
            end
            default: begin
                s_d.st = SCD_ST_STABLE;
            end
        endcase
        irq_set[`SCD_IRQ_PAR_ERR] = cb_parity_err;

        // sticky status, write one to clear, a new event beats the clear
        for (int i = 0; i < `SCD_IRQ_N; i++) begin
            s_d.irq_sts[i] = (s_q.irq_sts[i] && !(wr_sts && reg_wdata[i])) || irq_set[i];
        end
        s_d.irq = |(s_d.irq_sts & s_d.irq_msk);

        // read data, one cycle after the strobe, zero elsewhere
        s_d.rdata = 32'h00000000;
        if (reg_rd) begin
            if (scd_hit(reg_addr, `SCD_OFF_SYSCTL)) begin
                s_d.rdata[`SCD_SC_PAR_EN]  = s_q.parity_en;
                s_d.rdata[`SCD_SC_RSVD]    = 1'h0;
                s_d.rdata[`SCD_SC_VOLT]    = s_q.volt;
                s_d.rdata[`SCD_SC_KEEP]    = s_q.keep;
                s_d.rdata[`SCD_SC_PIN_SEL] = s_q.pin_sel;
            end else if (scd_hit(reg_addr, `SCD_OFF_DEBOUNCE)) begin
                s_d.rdata[7:0] = s_q.deb;
            end else if (scd_hit(reg_addr, `SCD_OFF_IRQ_STS)) begin
                s_d.rdata[`SCD_IRQ_N-1:0] = s_q.irq_sts;
            end else if (scd_hit(reg_addr, `SCD_OFF_IRQ_MSK)) begin
                s_d.rdata[`SCD_IRQ_N-1:0] = s_q.irq_msk;
            end
        end

        // bus reset only restarts the filter; configuration survives it
        if (!bus_rst_b) begin
            s_d.st       = SCD_ST_STABLE;
            s_d.tick_cnt = '0;
            s_d.present  = s_q.raw;
        end
    end

    // ------------------------------------------------------------------
    // state register, global reset only
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q              <= '0;
            s_q.parity_en    <= `SCD_RST_PAR_EN;
            s_q.keep         <= `SCD_RST_KEEP;
            s_q.pin_sel      <= `SCD_RST_PIN_SEL;
            s_q.volt         <= `SCD_RST_VOLT;
            s_q.deb          <= `SCD_RST_DEBOUNCE;
            s_q.limit        <= `SCD_RST_DEBOUNCE;
            s_q.st           <= SCD_ST_STABLE;
            s_q.card_stop_ok <= 1'h1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata              = s_q.rdata;
    assign serr_req               = s_q.serr;
    assign clkrun_hold            = s_q.clkrun_hold;
    assign card_bus_clock_stop_ok = s_q.card_stop_ok;
    assign event_pin_out          = s_q.pin_out;
    assign event_pin_oe           = s_q.pin_oe;
    assign media_card_present     = s_q.present;
    assign irq                    = s_q.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking scd_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_parity_serr_gate: assert property (
        cb_parity_err |=> (serr_req == $past(s_q.parity_en)))
        else $error("parity error report does not follow enable");

    a_rsvd_bit_zero: assert property (
        (reg_rd && reg_addr == `SCD_OFF_SYSCTL) |=> !reg_rdata[`SCD_SC_RSVD])
        else $error("reserved system control bit read as one");

    a_voltage_read_back: assert property (
        (reg_rd && reg_addr == `SCD_OFF_SYSCTL)
            |=> (reg_rdata[`SCD_SC_VOLT] == $past(s_q.volt)))
        else $error("socket voltage bit mismatch");

    a_keep_holds_clock: assert property (
        (s_q.keep && clk_stop_req && !wr_sysctl) |=> (clkrun_hold && !card_bus_clock_stop_ok))
        else $error("clock allowed to stop while keep is set");

    a_clear_lets_stop: assert property (
        (!s_q.keep && !wr_sysctl) |=> (!clkrun_hold && card_bus_clock_stop_ok) [*2])
        else $error("clocks held while keep is clear");

    a_func_global_only: assert property (
        (reg_wr && reg_func != `SCD_FUNC_GLOBAL)
            |=> $stable({s_q.parity_en, s_q.keep, s_q.pin_sel}))
        else $error("global bits changed from a non-zero function");

    a_pin_pme_route: assert property (
        s_q.pin_sel |=> (event_pin_oe && event_pin_out == $past(pme_event)))
        else $error("event pin not carrying power event");

    a_pin_ring_route: assert property (
        (!s_q.pin_sel && ring_indicate_enable)
            |=> (event_pin_oe && event_pin_out == $past(ring_indicate_output)))
        else $error("event pin not carrying ring indicate");

    a_pin_released: assert property (
        (!s_q.pin_sel && !ring_indicate_enable) |=> !event_pin_oe)
        else $error("event pin driven while both selects are clear");

    a_bus_reset_keeps: assert property (
        (!bus_rst_b && !reg_wr) |=> $stable({s_q.parity_en, s_q.keep, s_q.pin_sel, s_q.deb}))
        else $error("configuration lost on bus reset");

    a_debounce_length: assert property (
        (bus_rst_b && $past(bus_rst_b) && $changed(media_card_present))
            |-> ($past(s_q.tick_cnt) == {1'h0, $past(s_q.limit)} + 9'h001))
        else $error("card detect accepted at wrong tick count");

    a_debounce_stable: assert property (
        (s_q.st == SCD_ST_SETTLE && s_q.raw == s_q.present && bus_rst_b)
            |=> (s_q.st == SCD_ST_STABLE && $stable(media_card_present)))
        else $error("bounce did not restart the debounce");

    a_irq_level: assert property (
        (|(s_q.irq_sts & s_q.irq_msk)) |-> irq)
        else $error("interrupt low with unmasked status set");

endmodule : scd_ctrl

// ===== inc/scd_pkg.sv
// types of the sysctl/debounce block
package scd_pkg;

    typedef enum logic [0:0] {
        SCD_ST_STABLE = 1'h0,
        SCD_ST_SETTLE = 1'h1
    } scd_deb_state_t;

    typedef struct packed {
        logic                 parity_en;
        logic                 keep;
        logic                 pin_sel;
        logic                 volt;
        logic [7:0]           deb;
        logic [1:0]           irq_sts;
        logic [1:0]           irq_msk;
        scd_deb_state_t       st;
        logic                 raw;
        logic                 present;
        logic [16:0]          presc;
        logic                 tick;
        logic [8:0]           tick_cnt;
        logic [7:0]           limit;
        logic                 serr;
        logic                 clkrun_hold;
        logic                 card_stop_ok;
        logic                 pin_out;
        logic                 pin_oe;
        logic                 irq;
        logic [31:0]          rdata;
    } scd_state_t;

endpackage : scd_pkg

// ===== inc/scd_regs.svh
// register offsets, field positions, reset values and timing counts of the sysctl/debounce block
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SCD_OFF_SYSCTL      8'h80
`define SCD_OFF_DEBOUNCE    8'h84
`define SCD_OFF_IRQ_STS     8'hA0
`define SCD_OFF_IRQ_MSK     8'hA4

// ----------------------------------------------------------------------
// system control field positions
// ----------------------------------------------------------------------
`define SCD_SC_PIN_SEL      0
`define SCD_SC_KEEP         1
`define SCD_SC_VOLT         2
`define SCD_SC_RSVD         3
`define SCD_SC_PAR_EN       4

// ----------------------------------------------------------------------
// interrupt status positions
// ----------------------------------------------------------------------
`define SCD_IRQ_CD_CHG      0
`define SCD_IRQ_PAR_ERR     1
`define SCD_IRQ_N           2

// ----------------------------------------------------------------------
// reset values and the global function number
// ----------------------------------------------------------------------
`define SCD_RST_PAR_EN      1'h0
`define SCD_RST_KEEP        1'h0
`define SCD_RST_PIN_SEL     1'h0
`define SCD_RST_VOLT        1'h0
`define SCD_RST_DEBOUNCE    8'h19
`define SCD_FUNC_GLOBAL     3'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SCD_TICK_US         2000
`define SCD_CLK_MHZ         40
`define SCD_PRESC_W         17

`endif

// ===== verif/scd_socket_model.sv
// socket-side model: card-detect line, parity errors, event sources, shared pin
`timescale 1ns/1ps
module scd_socket_model (
    // clock
    input  wire logic clk,
    // socket signals into the block
    output logic      media_card_detect,
    output logic      cb_parity_err,
    output logic      pme_event,
    output logic      ring_indicate_output,
    // shared pin from the block
    input  wire logic event_pin_out,
    input  wire logic event_pin_oe,
    output logic      pin_level
);
    // a released pin floats up to the board pull-up, so the last value never lingers
    assign pin_level = event_pin_oe ? event_pin_out : 1'b1;

    initial begin
        media_card_detect    = 1'b0;
        cb_parity_err        = 1'b0;
        pme_event            = 1'b0;
        ring_indicate_output = 1'b0;
    end

    task automatic cd_set(input logic lvl);
        @(posedge clk);
        media_card_detect <= lvl;
    endtask : cd_set

    task automatic parity_pulse();
        @(posedge clk);
        cb_parity_err <= 1'b1;
        @(posedge clk);
        cb_parity_err <= 1'b0;
    endtask : parity_pulse

    task automatic events(input logic pme, input logic ri);
        @(posedge clk);
        pme_event            <= pme;
        ring_indicate_output <= ri;
    endtask : events
endmodule : scd_socket_model

// ===== verif/tb.sv
// self-checking bench of the system control and card-detect debounce block
`timescale 1ns/1ps
`include "scd_regs.svh"
module tb;
    localparam int unsigned TICK = 8;
    logic        clk, rst_b, bus_rst_b, reg_wr, reg_rd, legacy_socket_voltage;
    logic        clk_stop_req, ring_indicate_enable, serr_req, clkrun_hold;
    logic        card_bus_clock_stop_ok, event_pin_out, event_pin_oe, pin_level;
    logic        media_card_detect, cb_parity_err, pme_event, ring_indicate_output;
    logic        media_card_present, irq;
    logic [7:0]  reg_addr;
    logic [2:0]  reg_func;
    logic [31:0] reg_wdata, reg_rdata;
    int          err_total, checked, n;
    logic        sel, en, v;

    scd_ctrl #(.TICK_CYCLES(TICK)) i_scd_ctrl (
        .clk(clk), .rst_b(rst_b), .bus_rst_b(bus_rst_b), .reg_addr(reg_addr),
        .reg_func(reg_func), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cb_parity_err(cb_parity_err), .serr_req(serr_req),
        .legacy_socket_voltage(legacy_socket_voltage), .clk_stop_req(clk_stop_req),
        .clkrun_hold(clkrun_hold), .card_bus_clock_stop_ok(card_bus_clock_stop_ok),
        .pme_event(pme_event), .ring_indicate_output(ring_indicate_output),
        .ring_indicate_enable(ring_indicate_enable), .event_pin_out(event_pin_out),
        .event_pin_oe(event_pin_oe), .media_card_detect(media_card_detect),
        .media_card_present(media_card_present), .irq(irq));

    scd_socket_model i_scd_socket_model (
        .clk(clk), .media_card_detect(media_card_detect), .cb_parity_err(cb_parity_err),
        .pme_event(pme_event), .ring_indicate_output(ring_indicate_output),
        .event_pin_out(event_pin_out), .event_pin_oe(event_pin_oe), .pin_level(pin_level));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------------------------------------
    // access and check tasks
    // ----------------------------------------------------------------------
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [2:0] f, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_func  <= f;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_func <= 3'h0;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd

    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
    endtask : do_reset

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // bounded wait for the debounced level; n counts edges after the input change
    task automatic wait_present(input logic lvl);
        n = 0;
        while (media_card_present !== lvl && n < 400) begin
            step(1);
            n++;
        end
        if (n >= 400) begin
            err_total++;
            $display("CHECK FAILED present wait expected %0d seen timeout", lvl);
            end_sim();
        end
    endtask : wait_present

    // ----------------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------------
    initial begin
        rst_b = 1'b0; bus_rst_b = 1'b1; reg_addr = 8'h00; reg_func = 3'h0;
        reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0; legacy_socket_voltage = 1'b0;
        clk_stop_req = 1'b0; ring_indicate_enable = 1'b0; err_total = 0; checked = 0;
        do_reset();
        rd(`SCD_OFF_DEBOUNCE, 32'h19, "debounce reset");
        rd(`SCD_OFF_SYSCTL, 32'h0, "sysctl reset");
        chk("stop_ok", 32'h1, {31'h0, card_bus_clock_stop_ok});
        rd(8'h90, 32'h0, "unmapped");
        $display("test reset done");
        wr(`SCD_OFF_SYSCTL, 3'h0, 32'h1F);
        rd(`SCD_OFF_SYSCTL, 32'h13, "sysctl ro bits");
        @(posedge clk) legacy_socket_voltage <= 1'b1;
        step(3);
        rd(`SCD_OFF_SYSCTL, 32'h17, "voltage 5v");
        wr(`SCD_OFF_SYSCTL, 3'h1, 32'h0);
        rd(`SCD_OFF_SYSCTL, 32'h17, "func1 write");
        wr(`SCD_OFF_SYSCTL, 3'h0, 32'h02);
        clk_stop_req <= 1'b1;
        step(2);
        chk("clkrun_hold", 32'h1, {31'h0, clkrun_hold});
        chk("stop_ok", 32'h0, {31'h0, card_bus_clock_stop_ok});
        wr(`SCD_OFF_SYSCTL, 3'h0, 32'h0);
        step(2);
        chk("clkrun_hold", 32'h0, {31'h0, clkrun_hold});
        chk("stop_ok", 32'h1, {31'h0, card_bus_clock_stop_ok});
        $display("test sysctl done");
        // only card-detect changes may raise irq; parity events stay masked
        wr(`SCD_OFF_IRQ_MSK, 3'h0, 32'h1);
        i_scd_socket_model.parity_pulse();
        #1;
        chk("serr off", 32'h0, {31'h0, serr_req});
        step(3);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(`SCD_OFF_IRQ_STS, 32'h2, "parity status");
        wr(`SCD_OFF_IRQ_STS, 3'h0, 32'h2);
        rd(`SCD_OFF_IRQ_STS, 32'h0, "status cleared");
        wr(`SCD_OFF_SYSCTL, 3'h0, 32'h10);
        i_scd_socket_model.parity_pulse();
        #1;
        chk("serr on", 32'h1, {31'h0, serr_req});
        $display("test parity done");
        for (int i = 0; i < 8; i++) begin
            {v, en, sel} = i[2:0];
            wr(`SCD_OFF_SYSCTL, 3'h0, {31'h0, sel});
            ring_indicate_enable <= en;
            i_scd_socket_model.events(v, ~v);
            step(3);
            chk("pin oe", {31'h0, sel | en}, {31'h0, event_pin_oe});
            chk("pin level", {31'h0, sel ? v : (en ? ~v : 1'b1)}, {31'h0, pin_level});
        end
        $display("test pin routing done");
        wr(`SCD_OFF_DEBOUNCE, 3'h0, 32'h05);
        wr(`SCD_OFF_SYSCTL, 3'h0, 32'h12);
        bus_rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        bus_rst_b <= 1'b1;
        rd(`SCD_OFF_DEBOUNCE, 32'h05, "debounce after bus reset");
        rd(`SCD_OFF_SYSCTL, 32'h16, "sysctl after bus reset");
        $display("test bus reset done");
        wr(`SCD_OFF_DEBOUNCE, 3'h0, 32'h0);
        i_scd_socket_model.cd_set(1'b1);
        wait_present(1'b1);
        chk("window 0", 32'h1, {31'h0, n <= TICK + 4});
        step(3);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(`SCD_OFF_IRQ_STS, 3'h0, 32'h1);
        step(3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(`SCD_OFF_DEBOUNCE, 3'h0, 32'h03);
        i_scd_socket_model.cd_set(1'b0);
        step(10);
        i_scd_socket_model.cd_set(1'b1);
        step(2);
        i_scd_socket_model.cd_set(1'b0);
        wait_present(1'b0);
        chk("window 3", 32'h1, {31'h0, n >= 3 * TICK && n <= 4 * TICK + 4});
        $display("test debounce done");
        do_reset();
        rd(`SCD_OFF_DEBOUNCE, 32'h19, "debounce global reset");
        rd(`SCD_OFF_SYSCTL, 32'h04, "sysctl global reset");
        $display("test global reset done");
        end_sim();
    end
endmodule : tb
